// ---- rtl/rtc_cfg.svh ----
// Register map, field positions, reset values and timing constants
// Notes on behaviour
// - Power failure forces the freeze-update flag high.
// - Clearing freeze-update flag resumes user copy refresh.
// - Twenty registers; user copies refreshed from counters.
// - Any time register write resets divider chain.
// - Reading time addresses suspends refresh until stop or pointer leaves them.
// - Time, alarm in BCD; control fields binary.
// - Count seconds to year from 32768 Hz.
// - Century bits top of hours; halt bit seconds.
// - Watchdog holds multiplier bits 6-2, resolution 1-0.
// - Alarm registers hold repeat bits; freeze at 0Ch.
// - Flags expose watchdog, alarm bits; read-only.
// - Square-wave rate in upper nibble; low zero.
// - Calibration adds or removes counts, speeds/slows.
// - Control bits 4-0 magnitude, bit 5 sign.
// - One second per minute shortened or lengthened.
// - Correct only first 2N minutes of sixty-four.
// - Test mode toggles output at 512 Hz.
// - Test rate ignores calibration setting.
// - Power failure clears frequency test bit.
// - Multi-function output is open drain only.
// - Halt bit stops oscillator; clear restarts it.
// - Fraction register always written as zero.
// - Pointer advances only on acknowledge clock.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_NREG 20
`define RTC_A_FRAC 5'h00
`define RTC_A_SEC 5'h01
`define RTC_A_MIN 5'h02
`define RTC_A_HOUR 5'h03
`define RTC_A_WDAY 5'h04
`define RTC_A_DATE 5'h05
`define RTC_A_MONTH 5'h06
`define RTC_A_YEAR 5'h07
`define RTC_A_CTRL 5'h08
`define RTC_A_WDOG 5'h09
`define RTC_A_ALMON 5'h0a
`define RTC_A_ALDATE 5'h0b
`define RTC_A_ALHOUR 5'h0c
`define RTC_A_ALMIN 5'h0d
`define RTC_A_ALSEC 5'h0e
`define RTC_A_FLAGS 5'h0f
`define RTC_A_SQW 5'h13

`define RTC_B_OSCHALT 7
`define RTC_B_CENT_EN 7
`define RTC_B_CENT 6
`define RTC_B_FREEZE 6
`define RTC_B_OUT 7
`define RTC_B_FT 6
`define RTC_B_SIGN 5
`define RTC_CAL_MSB 4
`define RTC_B_AFE 7
`define RTC_B_SQUARE_WAVE_ENABLE 6

`define RTC_RST_ZERO 8'h00
`define RTC_RST_SEC 8'h80
`define RTC_RST_CTRL 8'h80
`define RTC_RST_ALHOUR 8'h40
`define RTC_RST_ONE 8'h01

`define RTC_M_SEC 8'hff
`define RTC_M_MIN 8'h7f
`define RTC_M_HOUR 8'hff
`define RTC_M_WDAY 8'h07
`define RTC_M_DATE 8'h3f
`define RTC_M_MONTH 8'h1f
`define RTC_M_ALL 8'hff
`define RTC_M_WDOG 8'h7f
`define RTC_M_SQW 8'hf0

`define RTC_MAX_SEC 8'h59
`define RTC_MAX_HOUR 8'h23
`define RTC_MAX_WDAY 8'h07
`define RTC_MAX_MONTH 8'h12
`define RTC_MAX_YEAR 8'h99

`define RTC_CLK_HZ 250000000
`define RTC_OSC_HZ 32768
`define RTC_FT_HZ 512
`define RTC_SEC_TICKS 17'd32768
`define RTC_CAL_SHORT 17'd128
`define RTC_CAL_LONG 17'd256
`define RTC_CAL_SEC 7'h00
`define RTC_FT_LAST 5'((`RTC_OSC_HZ / `RTC_FT_HZ / 2) - 1)
`define RTC_HUND 7'd100
`define RTC_HUND_MAX 7'd99
`define RTC_TEN 7'd10

`endif

// ---- rtl/rtc_core.sv ----
// Timekeeping core: register map, divider, calibration, test output
`timescale 1ns/10ps
`default_nettype none
`include "rtc_cfg.svh"
module rtc_core
  import rtc_pkg::*;
#(
  parameter int OSC_DIV = `RTC_CLK_HZ / `RTC_OSC_HZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire hostReq_t hostReq,
  input wire logic powerFail,
  input wire logic wdFlagIn,
  input wire logic alarmFlagIn,
  output logic [7:0] rdData,
  output logic mfpOut,
  output logic mfpOe
);

  // ==========================================================
  // Storage
  logic [4:0] ptr_r;
  logic [7:0] regs_r [`RTC_NREG];
  logic [7:0] tm_r [1:7];
  logic [16:0] divCnt_r;
  logic [15:0] presc_r;
  logic [5:0] calMin_r;
  logic [4:0] ftCnt_r;
  logic ftTog_r;
  logic freeze_r;
  logic freeze_nxt;
  logic [7:0] rdData_r;
  logic mfpOe_r;
  logic mfpOut_r;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] bcdNext(input logic [7:0] v,
      input logic [7:0] top, input logic [7:0] lo);
    if (v == top)
      return lo;
    else if (v[3:0] == 4'h9)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return v + 8'h01;
  endfunction

  // Fixed-zero bits are masked so stray host bits never count
  function automatic logic [7:0] wrMask(input logic [4:0] a);
    case (a)
      `RTC_A_FRAC: return `RTC_RST_ZERO;
      `RTC_A_SEC: return `RTC_M_SEC;
      `RTC_A_MIN: return `RTC_M_MIN;
      `RTC_A_HOUR: return `RTC_M_HOUR;
      `RTC_A_WDAY: return `RTC_M_WDAY;
      `RTC_A_DATE: return `RTC_M_DATE;
      `RTC_A_MONTH: return `RTC_M_MONTH;
      `RTC_A_YEAR: return `RTC_M_ALL;
      `RTC_A_CTRL: return `RTC_M_ALL;
      `RTC_A_WDOG: return `RTC_M_WDOG;
      `RTC_A_ALMON: return `RTC_M_ALL;
      `RTC_A_ALDATE: return `RTC_M_ALL;
      `RTC_A_ALHOUR: return `RTC_M_ALL;
      `RTC_A_ALMIN: return `RTC_M_ALL;
      `RTC_A_ALSEC: return `RTC_M_ALL;
      `RTC_A_SQW: return `RTC_M_SQW;
      default: return `RTC_RST_ZERO;
    endcase
  endfunction

  function automatic logic [5:0] daysIn(input logic [4:0] mo,
      input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    case (mo)
      5'h02: return leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 6'h30;
      default: return 6'h31;
    endcase
  endfunction

  // ==========================================================
  // Decode
  wire [7:0] ctrl = regs_r[`RTC_A_CTRL];
  wire [7:0] alMon = regs_r[`RTC_A_ALMON];
  wire freezeUpdateFlag = regs_r[`RTC_A_ALHOUR][`RTC_B_FREEZE];
  wire freqTestBit = ctrl[`RTC_B_FT];
  wire oscHaltBit = tm_r[1][`RTC_B_OSCHALT];
  wire inRange = ptr_r < 5'(`RTC_NREG);
  wire timeAddr = ptr_r <= `RTC_A_YEAR;
  wire tmWr = hostReq.wrStrobe && timeAddr;
  wire [7:0] wrMasked = hostReq.wrData & wrMask(ptr_r);

  // Halted oscillator simply stops the tick; restart is immediate
  wire oscTick = !oscHaltBit && presc_r == 16'(OSC_DIV - 1);

  // ==========================================================
  // Calibration
  wire [4:0] calMag = ctrl[`RTC_CAL_MSB:0];
  wire calPos = ctrl[`RTC_B_SIGN];
  wire calActive = calMin_r < {calMag, 1'b0};
  wire calSec = calActive && tm_r[1][6:0] == `RTC_CAL_SEC;
  // Same net effect as blanking or splitting divide-by-256 pulses
  wire [16:0] secLen = !calSec ? `RTC_SEC_TICKS
      : calPos ? `RTC_SEC_TICKS + `RTC_CAL_LONG
      : `RTC_SEC_TICKS - `RTC_CAL_SHORT;
  wire secTick = oscTick && divCnt_r == secLen - 17'd1;

  // ==========================================================
  // Calendar carries
  // Literals cannot be part-selected, so the limits live on wires
  wire [7:0] maxSec = `RTC_MAX_SEC;
  wire [7:0] maxHour = `RTC_MAX_HOUR;
  wire [7:0] maxMonth = `RTC_MAX_MONTH;
  wire minC = secTick && tm_r[1][6:0] == maxSec[6:0];
  wire hrC = minC && tm_r[2][6:0] == maxSec[6:0];
  wire dayC = hrC && tm_r[3][5:0] == maxHour[5:0];
  wire [5:0] dim = daysIn(tm_r[6][4:0], tm_r[7]);
  wire monC = dayC && tm_r[5][5:0] == dim;
  wire yrC = monC && tm_r[6][4:0] == maxMonth[4:0];
  wire centC = yrC && tm_r[7] == `RTC_MAX_YEAR;
  wire centEn = tm_r[3][`RTC_B_CENT_EN];

  wire [7:0] secNx = bcdNext({1'b0, tm_r[1][6:0]}, `RTC_MAX_SEC,
      `RTC_RST_ZERO);
  wire [7:0] minNx = bcdNext(tm_r[2], `RTC_MAX_SEC, `RTC_RST_ZERO);
  wire [7:0] hrNx = bcdNext({2'b00, tm_r[3][5:0]}, `RTC_MAX_HOUR,
      `RTC_RST_ZERO);
  wire [7:0] wdNx = bcdNext(tm_r[4], `RTC_MAX_WDAY, `RTC_RST_ONE);
  wire [7:0] dtNx = bcdNext(tm_r[5], {2'b00, dim}, `RTC_RST_ONE);
  wire [7:0] moNx = bcdNext(tm_r[6], `RTC_MAX_MONTH, `RTC_RST_ONE);
  wire [7:0] yrNx = bcdNext(tm_r[7], `RTC_MAX_YEAR, `RTC_RST_ZERO);

  // ==========================================================
  // Fraction seen from the divider, clipped on long seconds
  wire [23:0] hProd = divCnt_r * `RTC_HUND;
  wire [6:0] hund = divCnt_r >= `RTC_SEC_TICKS ? `RTC_HUND_MAX
      : hProd[21:15];
  wire [6:0] hTen = hund / `RTC_TEN;
  wire [6:0] hOne = hund % `RTC_TEN;
  wire [7:0] fracBcd = {hTen[3:0], hOne[3:0]};

  // ==========================================================
  // Transfer control
  always_comb begin
    if (hostReq.stopCond)
      freeze_nxt = 1'b0;
    else if (hostReq.readActive && timeAddr)
      freeze_nxt = 1'b1;
    else if (!timeAddr)
      freeze_nxt = 1'b0;
    else
      freeze_nxt = freeze_r;
  end
  wire xferEn = !freezeUpdateFlag && !freeze_r;

  // ==========================================================
  // Output pin selection
  wire wdZero = regs_r[`RTC_A_WDOG] == `RTC_RST_ZERO;
  wire othersOff = !alMon[`RTC_B_AFE] && !alMon[`RTC_B_SQUARE_WAVE_ENABLE] && wdZero;
  wire ftSel = freqTestBit && othersOff;
  // Alarm, watchdog and square wave drive elsewhere; released here
  wire mfpMode_t mfpMode = ftSel ? MFP_TEST
      : othersOff ? MFP_LEVEL : MFP_RELEASE;
  wire pullLow = mfpMode == MFP_TEST ? !ftTog_r
      : mfpMode == MFP_LEVEL ? !ctrl[`RTC_B_OUT] : 1'b0;
  wire [7:0] rdMux = !inRange ? `RTC_RST_ZERO
      : ptr_r == `RTC_A_FLAGS ? {wdFlagIn, alarmFlagIn, 6'h00}
      : regs_r[ptr_r];

  // ==========================================================
  // Oscillator prescaler and divider chain
  always_ff @(posedge clk) begin
    if (reset || oscHaltBit || oscTick)
      presc_r <= 16'h0000;
    else
      presc_r <= presc_r + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      divCnt_r <= 17'h00000;
      calMin_r <= 6'h00;
    end else begin
      if (tmWr || secTick)
        divCnt_r <= 17'h00000;
      else if (oscTick)
        divCnt_r <= divCnt_r + 17'h00001;
      if (minC && !tmWr)
        calMin_r <= calMin_r + 6'h01;
    end
  end

  // Free of calibration: the test tone stays a true oscillator tap
  always_ff @(posedge clk) begin
    if (reset) begin
      ftCnt_r <= 5'h00;
      ftTog_r <= 1'b0;
    end else if (oscTick) begin
      ftCnt_r <= ftCnt_r + 5'h01;
      if (ftCnt_r == `RTC_FT_LAST)
        ftTog_r <= !ftTog_r;
    end
  end

  // ==========================================================
  // Internal counting copy
  always_ff @(posedge clk) begin
    if (reset) begin
      tm_r[1] <= `RTC_RST_SEC;
      tm_r[2] <= `RTC_RST_ZERO;
      tm_r[3] <= `RTC_RST_ZERO;
      tm_r[4] <= `RTC_RST_ONE;
      tm_r[5] <= `RTC_RST_ONE;
      tm_r[6] <= `RTC_RST_ONE;
      tm_r[7] <= `RTC_RST_ZERO;
    end else if (tmWr) begin
      if (ptr_r != `RTC_A_FRAC)
        tm_r[ptr_r[2:0]] <= wrMasked;
    end else begin
      if (secTick)
        tm_r[1] <= {tm_r[1][7], secNx[6:0]};
      if (minC)
        tm_r[2] <= minNx;
      if (hrC)
        tm_r[3] <= {centEn, tm_r[3][`RTC_B_CENT] ^ (centC && centEn),
            hrNx[5:0]};
      if (dayC) begin
        tm_r[4] <= wdNx;
        tm_r[5] <= dtNx;
      end
      if (monC)
        tm_r[6] <= moNx;
      if (yrC)
        tm_r[7] <= yrNx;
    end
  end

  // ==========================================================
  // User-visible register file
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `RTC_NREG; i++)
        regs_r[i] <= `RTC_RST_ZERO;
      regs_r[`RTC_A_SEC] <= `RTC_RST_SEC;
      regs_r[`RTC_A_WDAY] <= `RTC_RST_ONE;
      regs_r[`RTC_A_DATE] <= `RTC_RST_ONE;
      regs_r[`RTC_A_MONTH] <= `RTC_RST_ONE;
      regs_r[`RTC_A_CTRL] <= `RTC_RST_CTRL;
      regs_r[`RTC_A_ALHOUR] <= `RTC_RST_ALHOUR;
    end else begin
      if (xferEn) begin
        regs_r[`RTC_A_FRAC] <= fracBcd;
        for (int i = 1; i < 8; i++)
          regs_r[i] <= tm_r[i];
      end
      if (hostReq.wrStrobe && inRange)
        regs_r[ptr_r] <= wrMasked;
      if (powerFail) begin
        regs_r[`RTC_A_ALHOUR][`RTC_B_FREEZE] <= 1'b1;
        regs_r[`RTC_A_CTRL][`RTC_B_FT] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Pointer, read data, pin
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_r <= `RTC_A_FRAC;
      freeze_r <= 1'b0;
      rdData_r <= `RTC_RST_ZERO;
      mfpOe_r <= 1'b0;
      mfpOut_r <= 1'b0;
    end else begin
      if (hostReq.ptrLoad)
        ptr_r <= hostReq.addr;
      else if (hostReq.ackClk)
        ptr_r <= ptr_r == `RTC_A_SQW ? `RTC_A_FRAC : ptr_r + 5'h01;
      freeze_r <= freeze_nxt;
      rdData_r <= rdMux;
      mfpOe_r <= pullLow;
      mfpOut_r <= 1'b0;
    end
  end

  assign rdData = rdData_r;
  assign mfpOut = mfpOut_r;
  assign mfpOe = mfpOe_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seqTimeWrite;
    hostReq.wrStrobe && timeAddr;
  endsequence
  sequence seqReadTime;
    hostReq.readActive && !hostReq.stopCond && timeAddr;
  endsequence
  sequence seqFtEdge;
    ftSel && oscTick && ftCnt_r == `RTC_FT_LAST;
  endsequence

  AST_HT_ON_FAIL: assert property (powerFail |=> freezeUpdateFlag)
    else $error("freeze flag not set after power fail");
  AST_HT_HOLDS: assert property (freezeUpdateFlag && !hostReq.wrStrobe
      |=> regs_r[`RTC_A_SEC] == $past(regs_r[`RTC_A_SEC]))
    else $error("user seconds changed while frozen");
  AST_COPY_RESUME: assert property (xferEn && !hostReq.wrStrobe
      |=> regs_r[`RTC_A_MIN] == $past(tm_r[2]))
    else $error("user minutes not refreshed");
  AST_DIV_RESET: assert property (seqTimeWrite |=> divCnt_r == 17'h00000)
    else $error("divider not reset by time write");
  AST_READ_FREEZE: assert property (seqReadTime |=> !xferEn)
    else $error("transfer not suspended on time read");
  AST_STOP_RESUME: assert property (hostReq.stopCond |=> !freeze_r)
    else $error("stop did not release freeze");
  AST_FLAGS_LOW: assert property (ptr_r == `RTC_A_FLAGS && !hostReq.ptrLoad
      && !hostReq.ackClk |=> rdData_r[5:0] == 6'h00)
    else $error("flags low bits not zero");
  AST_SQW_LOW: assert property (regs_r[`RTC_A_SQW][3:0] == 4'h0)
    else $error("square wave low nibble set");
  AST_CAL_LONG: assert property (calSec && calPos && oscTick
      && divCnt_r == `RTC_SEC_TICKS - 17'd1 |-> !secTick)
    else $error("positive correction second not lengthened");
  AST_FT_EDGE: assert property (seqFtEdge ##1 ftSel
      |=> mfpOe_r != $past(mfpOe_r))
    else $error("test output failed to toggle");
  AST_FT_CLEAR: assert property (powerFail |=> !freqTestBit)
    else $error("test bit survived power fail");
  AST_OPEN_DRAIN: assert property (!mfpOut_r)
    else $error("pin driven high");
  AST_FRAC_ZERO: assert property (hostReq.wrStrobe
      && ptr_r == `RTC_A_FRAC |=> regs_r[`RTC_A_FRAC] == `RTC_RST_ZERO)
    else $error("fraction write not forced to zero");
  AST_PTR_STEP: assert property (hostReq.ackClk && !hostReq.ptrLoad
      && ptr_r < `RTC_A_SQW |=> ptr_r == $past(ptr_r) + 5'h01)
    else $error("pointer did not advance");

endmodule
`default_nettype wire

// ---- rtl/rtc_pkg.sv ----
// Shared types of the timekeeping core
package rtc_pkg;

  typedef struct packed {
    logic ptrLoad;
    logic [4:0] addr;
    logic wrStrobe;
    logic [7:0] wrData;
    logic ackClk;
    logic readActive;
    logic stopCond;
  } hostReq_t;

  typedef enum logic [1:0] {MFP_TEST, MFP_LEVEL, MFP_RELEASE} mfpMode_t;

endpackage

// ---- verif/host_model.sv ----
// Host bus master model driving register requests to the core
`timescale 1ns/10ps
`default_nettype none
module host_model
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdData,
  output var hostReq_t req
);
  // ==========
  // Bus cycles
  // ==========
  initial begin
    req = '0;
  end

  task automatic cyc();
    @(posedge clk);
    #1;
  endtask

  // Released data shows inverse, never the stale byte
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    cyc();
    req.ptrLoad = 1'b1;
    req.addr = a;
    cyc();
    req.ptrLoad = 1'b0;
    req.wrStrobe = 1'b1;
    req.wrData = d;
    req.ackClk = 1'b1;
    cyc();
    req.wrStrobe = 1'b0;
    req.ackClk = 1'b0;
    req.wrData = ~d;
  endtask

  // Back-to-back bytes, one acknowledge clock each
  task automatic write_pair(input logic [4:0] a, input logic [7:0] d0,
                            input logic [7:0] d1);
    cyc();
    req.ptrLoad = 1'b1;
    req.addr = a;
    cyc();
    req.ptrLoad = 1'b0;
    req.wrStrobe = 1'b1;
    req.wrData = d0;
    req.ackClk = 1'b1;
    cyc();
    req.wrData = d1;
    cyc();
    req.wrStrobe = 1'b0;
    req.ackClk = 1'b0;
    req.wrData = ~d1;
  endtask

  // Stop ends the read so user copies refresh again
  task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
    cyc();
    req.ptrLoad = 1'b1;
    req.addr = a;
    req.readActive = 1'b1;
    cyc();
    req.ptrLoad = 1'b0;
    cyc();
    d = rdData;
    req.ackClk = 1'b1;
    req.stopCond = 1'b1;
    req.readActive = 1'b0;
    cyc();
    req.ackClk = 1'b0;
    req.stopCond = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking testbench of the timekeeping core
`timescale 1ns/10ps
`default_nettype none
`include "rtc_cfg.svh"
module tb;
  import rtc_pkg::*;
  localparam int OSC = 2;
  localparam int SEC = 32768 * OSC;
  logic clk, reset, powerFail, wdFlagIn, alarmFlagIn;
  logic mfpOut, mfpOe;
  logic [7:0] rdData, got;
  hostReq_t hostReq;
  int error_cnt = 0;
  int checked = 0;
  int cycleCnt = 0;
  logic [4:0] addrT [8] = '{5'h01, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0c,
                            5'h09, 5'h13};
  logic [7:0] rstT [8] = '{8'h80, 8'h01, 8'h01, 8'h01, 8'h80, 8'h40,
                           8'h00, 8'h00};
  logic [4:0] mskA [5] = '{5'h09, 5'h13, 5'h04, 5'h10, 5'h00};
  logic [7:0] mskE [5] = '{8'h7f, 8'hf0, 8'h07, 8'h00, 8'h00};

  rtc_core #(.OSC_DIV(OSC)) dut (.clk(clk), .reset(reset),
    .hostReq(hostReq), .powerFail(powerFail), .wdFlagIn(wdFlagIn),
    .alarmFlagIn(alarmFlagIn), .rdData(rdData), .mfpOut(mfpOut),
    .mfpOe(mfpOe));
  host_model host (.clk(clk), .rdData(rdData), .req(hostReq));

  // ==========
  // Helpers
  // ==========
  function automatic logic [7:0] bcd(input int n);
    return 8'(((n / 10) << 4) | (n % 10));
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Cycles between two pin transitions, bounded
  task automatic per_chk(input string nm);
    int n;
    logic last;
    // First change may be the mode switch, so skip two edges
    for (int k = 0; k < 3; k++) begin
      n = 0;
      last = mfpOe;
      while (mfpOe === last && n < 200) begin
        wait_cyc(1);
        n++;
      end
    end
    chk(nm, 8'd64, 8'(n));
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========
  // Clock and watchdogs
  // ==========
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Open drain pin never driven high
  always @(posedge clk) begin
    cycleCnt <= cycleCnt + 1;
    if (!reset && mfpOut !== 1'b0) begin
      error_cnt++;
      $display("[ERR] mfpOut expected 0 seen %b", mfpOut);
    end
    if (cycleCnt == 90000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========
  // Scenarios
  // ==========
  initial begin
    int m;
    reset = 1'b1;
    powerFail = 1'b0;
    wdFlagIn = 1'b0;
    alarmFlagIn = 1'b0;
    void'($urandom(32'h94f1065c));
    wait_cyc(20);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      host.read_reg(addrT[i], got);
      chk("reset value", rstT[i], got);
    end
    for (int i = 0; i < 5; i++) begin
      host.write_reg(mskA[i], 8'hff);
      host.read_reg(mskA[i], got);
      chk("masked write", mskE[i], got);
    end
    host.write_reg(5'h00, 8'($urandom()));
    host.read_reg(5'h00, got);
    chk("fraction", 8'h00, got);
    wdFlagIn = 1'($urandom());
    alarmFlagIn = 1'($urandom());
    host.write_reg(5'h0f, 8'hff);
    host.read_reg(5'h0f, got);
    chk("flags", {wdFlagIn, alarmFlagIn, 6'h00}, got);
    host.write_pair(5'h0d, 8'h8a, 8'h95);
    host.read_reg(5'h0e, got);
    chk("pointer advance", 8'h95, got);
    m = $urandom_range(59);
    host.write_reg(5'h02, bcd(m));
    host.read_reg(5'h02, got);
    chk("minutes", bcd(m), got);
    // Divider restarts at the write, so the second edge is exact
    host.write_reg(5'h0c, 8'h00);
    host.write_reg(5'h01, 8'h05);
    wait_cyc(SEC - 20);
    host.read_reg(5'h01, got);
    chk("seconds early", 8'h05, got);
    wait_cyc(40);
    host.read_reg(5'h01, got);
    chk("seconds tick", 8'h06, got);
    host.write_reg(5'h09, 8'h00);
    host.write_reg(5'h08, 8'h40);
    per_chk("test period");
    host.write_reg(5'h08, 8'h7f);
    per_chk("test period cal");
    host.write_reg(5'h08, 8'h00);
    wait_cyc(4);
    chk("level low", 8'h01, {7'h00, mfpOe});
    host.write_reg(5'h08, 8'hc0);
    powerFail = 1'b1;
    wait_cyc(1);
    powerFail = 1'b0;
    host.read_reg(5'h0c, got);
    chk("freeze flag", 8'h40, got & 8'h40);
    host.read_reg(5'h08, got);
    chk("test bit", 8'h80, got);
    wait_cyc(4);
    chk("level high", 8'h00, {7'h00, mfpOe});
    finish_test();
  end
endmodule
`default_nettype wire
